/* File: hdl/fcs_regs.svh */
// Timing counts and command codes used by the flash host controller.
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH
`define FCS_CLK_MHZ 100
`define FCS_ADDR_UNLOCK1 16'h5555
`define FCS_ADDR_UNLOCK2 16'h2AAA
`define FCS_DATA_UNLOCK1 8'hAA
`define FCS_DATA_UNLOCK2 8'h55
`define FCS_CMD_PROGRAM 8'hA0
`define FCS_CMD_ERASE_SETUP 8'h80
`define FCS_CMD_CHIP_ERASE 8'h10
`define FCS_CMD_SECTOR_ERASE 8'h30
`define FCS_CMD_ID_ENTRY 8'h90
`define FCS_CMD_ID_EXIT 8'hF0
`define FCS_ADDR_MAKER 17'h00000
`define FCS_ADDR_PART 17'h00001
// Strobe low time in ns, well above the glitch filter width
`define FCS_STROBE_NS 40
// Read cycle time in ns and the settle time in ns
`define FCS_READ_NS 90
`define FCS_SETTLE_NS 1000
`define FCS_SECTOR_LSB 12
`define FCS_POLL_BIT 7
`define FCS_TOGGLE_BIT 6
`define FCS_STROBE_CYC ((`FCS_STROBE_NS * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_READ_CYC ((`FCS_READ_NS * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_SETTLE_CYC ((`FCS_SETTLE_NS * `FCS_CLK_MHZ + 999) / 1000)
`endif

/* File: hdl/fcs_pkg.sv */
// Types shared by the flash host controller modules.
package fcs_pkg;
    typedef enum logic [2:0] {
        FCS_OP_READ = 3'h0,
        FCS_OP_PROGRAM = 3'h1,
        FCS_OP_SECTOR_ERASE = 3'h2,
        FCS_OP_CHIP_ERASE = 3'h3,
        FCS_OP_ID_ENTRY = 3'h4,
        FCS_OP_ID_EXIT = 3'h5,
        FCS_OP_ID_EXIT_LONG = 3'h6
    } fcs_op_e;
endpackage

/* File: hdl/fcs_bus_if.sv */
// Internal bus cycle request between sequencer and pin cycle engine.
`timescale 1ns/1ps
interface fcs_bus_if;
    logic req;
    logic wr;
    logic [16:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    modport seq(output req, output wr, output addr, output wdata, input done, input rdata);
    modport eng(input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

/* File: hdl/fcs_cycle.sv */
// Pin cycle engine: one read or one write cycle on the flash pins.
`timescale 1ns/1ps
`include "fcs_regs.svh"
module fcs_cycle
    import fcs_pkg::*;
#(
    parameter int STROBE_CYC = `FCS_STROBE_CYC,
    parameter int READ_CYC = `FCS_READ_CYC
) (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset
    fcs_bus_if.eng bus, // Cycle request
    output logic ce_n, // Chip select
    output logic oe_n, // Output gate
    output logic we_n, // Write strobe
    output logic [16:0] addr, // Address pins
    output logic [7:0] dq_out, // Data driven
    output logic dq_oe_n, // Data drive enable, low drives
    input wire logic [7:0] dq_in // Data sampled
);
    typedef enum logic [1:0] {FCS_CY_IDLE = 2'b00, FCS_CY_ACT = 2'b01, FCS_CY_HOLD = 2'b11} fcs_cy_e;
    fcs_cy_e st_reg, st_next;
    logic [7:0] cnt_reg, cnt_next;
    logic ce_n_reg, ce_n_next, oe_n_reg, oe_n_next, we_n_reg, we_n_next, dqoe_reg, dqoe_next;
    logic [16:0] a_reg, a_next;
    logic [7:0] d_reg, d_next, r_reg, r_next;
    logic done_reg, done_next;

    // Address, chip select and strobe driven in the same cycle, strobe held low, then one idle cycle of hold
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        ce_n_next = ce_n_reg;
        oe_n_next = oe_n_reg;
        we_n_next = we_n_reg;
        dqoe_next = dqoe_reg;
        a_next = a_reg;
        d_next = d_reg;
        r_next = r_reg;
        done_next = 1'b0;
        unique case (st_reg)
            FCS_CY_IDLE: begin
                if (bus.req) begin
                    a_next = bus.addr;
                    d_next = bus.wdata;
                    ce_n_next = 1'b0;
                    // Gate high on a write so the write is never inhibited
                    oe_n_next = bus.wr;
                    we_n_next = ~bus.wr;
                    dqoe_next = ~bus.wr;
                    cnt_next = bus.wr ? 8'(STROBE_CYC - 1) : 8'(READ_CYC - 1);
                    st_next = FCS_CY_ACT;
                end
            end
            FCS_CY_ACT: begin
                if (cnt_reg == 8'h00) begin
                    r_next = dq_in;
                    ce_n_next = 1'b1;
                    oe_n_next = 1'b1;
                    we_n_next = 1'b1;
                    st_next = FCS_CY_HOLD;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            FCS_CY_HOLD: begin
                dqoe_next = 1'b1;
                done_next = 1'b1;
                st_next = FCS_CY_IDLE;
            end
            default: st_next = FCS_CY_IDLE;
        endcase
    end

    // Register stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= FCS_CY_IDLE;
            cnt_reg <= 8'h00;
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            dqoe_reg <= 1'b1;
            a_reg <= 17'h00000;
            d_reg <= 8'h00;
            r_reg <= 8'h00;
            done_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            ce_n_reg <= ce_n_next;
            oe_n_reg <= oe_n_next;
            we_n_reg <= we_n_next;
            dqoe_reg <= dqoe_next;
            a_reg <= a_next;
            d_reg <= d_next;
            r_reg <= r_next;
            done_reg <= done_next;
        end
    end

    assign ce_n = ce_n_reg;
    assign oe_n = oe_n_reg;
    assign we_n = we_n_reg;
    assign dq_oe_n = dqoe_reg;
    assign addr = a_reg;
    assign dq_out = d_reg;
    assign bus.done = done_reg;
    assign bus.rdata = r_reg;

    // Write strobe never low while the output gate is low
    wr_gate_a: assert property (@(posedge clk) disable iff (sys_rst) !we_n_reg |-> oe_n_reg && !ce_n_reg)
        else $error("write strobe with gate low");
    // Write strobe low for the full width
    wr_width_a: assert property (@(posedge clk) disable iff (sys_rst) $fell(we_n_reg) |-> !we_n_reg [*4])
        else $error("write strobe too short");
endmodule

/* File: hdl/fcs_host.sv */
// Flash host controller: command sequences and completion polling.
`timescale 1ns/1ps
`include "fcs_regs.svh"
module fcs_host
    import fcs_pkg::*;
#(
    parameter int SETTLE_CYC = `FCS_SETTLE_CYC
) (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset
    input wire logic cmd_valid, // Start an operation
    input wire fcs_op_e cmd_op, // Operation kind
    input wire logic [16:0] cmd_addr, // Target byte or sector address
    input wire logic [7:0] cmd_data, // Byte to program
    output logic cmd_ready, // Idle, may take a command
    output logic rsp_valid, // Operation finished, one cycle
    output logic [7:0] rsp_data, // Read or identification byte
    output logic ce_n, // Chip select
    output logic oe_n, // Output gate
    output logic we_n, // Write strobe
    output logic [16:0] addr, // Address pins
    output logic [7:0] dq_out, // Data driven
    output logic dq_oe_n, // Data drive enable, low drives
    input wire logic [7:0] dq_in // Data sampled
);
    // ****************************************
    // Sequencer
    // ****************************************
    typedef enum logic [2:0] {
        FCS_IDLE = 3'b000, FCS_WRITE = 3'b001, FCS_POLL = 3'b011,
        FCS_SETTLE = 3'b010, FCS_FINAL = 3'b110, FCS_DONE = 3'b111
    } fcs_st_e;
    fcs_st_e st_reg, st_next;
    fcs_op_e op_reg, op_next;
    logic [2:0] step_reg, step_next, nstep;
    logic [16:0] ta_reg, ta_next;
    logic [7:0] td_reg, td_next, last_reg, last_next, rsp_reg, rsp_next;
    logic [15:0] sc_reg, sc_next;
    logic req_reg, req_next, ready_reg, ready_next, rv_reg, rv_next, first_reg, first_next;
    logic [16:0] wa;
    logic [7:0] wd;
    logic erase_op;
    fcs_bus_if bus();

    assign erase_op = (op_reg == FCS_OP_SECTOR_ERASE) || (op_reg == FCS_OP_CHIP_ERASE);

    // Number of writes per operation
    always_comb begin
        unique case (op_reg)
            FCS_OP_PROGRAM: nstep = 3'd4;
            FCS_OP_SECTOR_ERASE, FCS_OP_CHIP_ERASE: nstep = 3'd6;
            FCS_OP_ID_ENTRY, FCS_OP_ID_EXIT_LONG: nstep = 3'd3;
            FCS_OP_ID_EXIT: nstep = 3'd1;
            default: nstep = 3'd0;
        endcase
    end

    // Address and data of each write; bit 16 left low on command writes other than the sector erase write
    always_comb begin
        wa = {1'b0, `FCS_ADDR_UNLOCK1};
        wd = `FCS_DATA_UNLOCK1;
        unique case (step_reg)
            3'd0: begin
                wd = (op_reg == FCS_OP_ID_EXIT) ? `FCS_CMD_ID_EXIT : `FCS_DATA_UNLOCK1;
            end
            3'd1, 3'd4: begin
                wa = {1'b0, `FCS_ADDR_UNLOCK2};
                wd = `FCS_DATA_UNLOCK2;
            end
            3'd2: begin
                unique case (op_reg)
                    FCS_OP_PROGRAM: wd = `FCS_CMD_PROGRAM;
                    FCS_OP_ID_ENTRY: wd = `FCS_CMD_ID_ENTRY;
                    FCS_OP_ID_EXIT_LONG: wd = `FCS_CMD_ID_EXIT;
                    default: wd = `FCS_CMD_ERASE_SETUP;
                endcase
            end
            3'd3: begin
                if (op_reg == FCS_OP_PROGRAM) begin
                    wa = ta_reg;
                    wd = td_reg;
                end
            end
            3'd5: begin
                if (op_reg == FCS_OP_SECTOR_ERASE) begin
                    // Only the sector field matters; low bits cleared
                    wa = {ta_reg[16:`FCS_SECTOR_LSB], 12'h000};
                    wd = `FCS_CMD_SECTOR_ERASE;
                end else begin
                    wd = `FCS_CMD_CHIP_ERASE;
                end
            end
            default: wd = `FCS_DATA_UNLOCK1;
        endcase
    end

    // Sequence of writes, then polling for program and erase; nothing new is issued while busy
    always_comb begin
        st_next = st_reg;
        op_next = op_reg;
        step_next = step_reg;
        ta_next = ta_reg;
        td_next = td_reg;
        last_next = last_reg;
        rsp_next = rsp_reg;
        sc_next = sc_reg;
        req_next = 1'b0;
        ready_next = ready_reg;
        rv_next = 1'b0;
        first_next = first_reg;
        unique case (st_reg)
            FCS_IDLE: begin
                if (cmd_valid) begin
                    op_next = cmd_op;
                    ta_next = cmd_addr;
                    td_next = cmd_data;
                    step_next = 3'd0;
                    ready_next = 1'b0;
                    req_next = 1'b1;
                    st_next = (cmd_op == FCS_OP_READ) ? FCS_FINAL : FCS_WRITE;
                end
            end
            FCS_WRITE: begin
                if (bus.done) begin
                    if (step_reg == nstep - 3'd1) begin
                        // Status is valid after the last strobe rises
                        first_next = 1'b1;
                        req_next = (op_reg == FCS_OP_PROGRAM) || erase_op;
                        st_next = req_next ? FCS_POLL : FCS_DONE;
                    end else begin
                        step_next = step_reg + 3'd1;
                        req_next = 1'b1;
                    end
                end
            end
            FCS_POLL: begin
                if (bus.done) begin
                    last_next = bus.rdata;
                    first_next = 1'b0;
                    // Two equal toggle bits in a row mean done
                    if (!first_reg && (bus.rdata[`FCS_TOGGLE_BIT] == last_reg[`FCS_TOGGLE_BIT])) begin
                        sc_next = 16'(SETTLE_CYC);
                        st_next = FCS_SETTLE;
                    end else begin
                        req_next = 1'b1;
                    end
                end
            end
            FCS_SETTLE: begin
                if (sc_reg == 16'h0000) begin
                    req_next = 1'b1;
                    st_next = FCS_FINAL;
                end else begin
                    sc_next = sc_reg - 16'h0001;
                end
            end
            FCS_FINAL: begin
                if (bus.done) begin
                    rsp_next = bus.rdata;
                    st_next = FCS_DONE;
                end
            end
            FCS_DONE: begin
                rv_next = 1'b1;
                ready_next = 1'b1;
                st_next = FCS_IDLE;
            end
            default: st_next = FCS_IDLE;
        endcase
    end

    // Register stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= FCS_IDLE;
            op_reg <= FCS_OP_READ;
            step_reg <= 3'd0;
            ta_reg <= 17'h00000;
            td_reg <= 8'h00;
            last_reg <= 8'h00;
            rsp_reg <= 8'h00;
            sc_reg <= 16'h0000;
            req_reg <= 1'b0;
            ready_reg <= 1'b1;
            rv_reg <= 1'b0;
            first_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            op_reg <= op_next;
            step_reg <= step_next;
            ta_reg <= ta_next;
            td_reg <= td_next;
            last_reg <= last_next;
            rsp_reg <= rsp_next;
            sc_reg <= sc_next;
            req_reg <= req_next;
            ready_reg <= ready_next;
            rv_reg <= rv_next;
            first_reg <= first_next;
        end
    end

    // Polls and final read use the target address
    assign bus.req = req_reg;
    assign bus.wr = (st_reg == FCS_WRITE);
    assign bus.addr = (st_reg == FCS_WRITE) ? wa : ta_reg;
    assign bus.wdata = wd;
    assign cmd_ready = ready_reg;
    assign rsp_valid = rv_reg;
    assign rsp_data = rsp_reg;

    // ****************************************
    // Pin cycle engine
    // ****************************************
    fcs_cycle u_cycle (
        .clk(clk),
        .sys_rst(sys_rst),
        .bus(bus),
        .ce_n(ce_n),
        .oe_n(oe_n),
        .we_n(we_n),
        .addr(addr),
        .dq_out(dq_out),
        .dq_oe_n(dq_oe_n),
        .dq_in(dq_in)
    );

    // Final read issued right after the settle wait ends
    settle_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
        (st_reg == FCS_SETTLE && sc_reg == 16'h0000) |=> st_reg == FCS_FINAL)
        else $error("final read not after settle");
    // A sixth write is only ever sent by an erase
    erase_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        (st_reg == FCS_WRITE && $past(st_reg) == FCS_WRITE && step_reg == 3'd5 && bus.done) |-> erase_op)
        else $error("sixth write outside erase");
    // No command accepted while polling
    busy_block_a: assert property (@(posedge clk) disable iff (sys_rst)
        (st_reg == FCS_POLL) |-> !ready_reg)
        else $error("ready while polling");
    // Sector erase last write carries 30H
    sector_cmd_a: assert property (@(posedge clk) disable iff (sys_rst)
        (st_reg == FCS_WRITE && step_reg == 3'd5 && op_reg == FCS_OP_SECTOR_ERASE) |-> wd == 8'h30)
        else $error("sector erase code wrong");
    // Program third write carries A0H at the unlock address
    prog_cmd_a: assert property (@(posedge clk) disable iff (sys_rst)
        (st_reg == FCS_WRITE && step_reg == 3'd2 && op_reg == FCS_OP_PROGRAM) |-> wd == 8'hA0 && wa == 17'h05555)
        else $error("program code wrong");
    // Done pulse lasts one cycle
    rsp_pulse_a: assert property (@(posedge clk) disable iff (sys_rst) rsp_valid |=> !rsp_valid)
        else $error("done pulse too long");
endmodule

/* File: testbench/fcs_flash_model.sv */
// Behavioural model of the byte-wide flash device on the far side of the host.
`timescale 1ns/1ps
module fcs_flash_model #(
    parameter int PROG_CYC = 60, // Internal program time in clocks
    parameter int ERASE_CYC = 300, // Internal erase time in clocks
    parameter int SETTLE_CYC = 5, // Low bits unreliable this long after program
    parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
    parameter logic [7:0] PART_CODE = 8'hC3 // Arbitrary value
) (
    input wire logic clk, // Model time base
    input wire logic ce_n, // Chip select
    input wire logic oe_n, // Output gate
    input wire logic we_n, // Write strobe
    input wire logic [16:0] addr, // Address pins
    input wire logic [7:0] dq_out, // Data from host
    input wire logic dq_oe_n, // Host drives when low
    output logic [7:0] dq_in // Data to host
);
    logic [7:0] mem [bit [16:0]];
    logic wr_prev = 0, rd_prev = 0, id_mode = 0, erasing = 0, tog = 0;
    logic [16:0] a_lat = '0;
    logic [7:0] d_lat = '0, d_prog = '0, last = '0, out;
    int step = 0, busy = 0, settle = 0, bad_cnt = 0, ignored_cnt = 0;
    wire wr_act = !ce_n && !we_n && oe_n;
    wire rd_act = !ce_n && !oe_n && we_n;

    initial dq_in = 8'h00;

    function automatic logic [7:0] rd_val(input logic [16:0] a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction

    // Busy interval starts at the write that ends the sequence
    task automatic start(input int n, input logic e);
        busy = n;
        erasing = e;
        step = 0;
    endtask

    // Command decoder; step 9 marks an abandoned sequence
    task automatic take(input logic [16:0] a, input logic [7:0] d);
        logic [15:0] m;
        m = a[15:0];
        if (busy > 0) begin
            ignored_cnt++;
            return;
        end
        if (d == 8'hF0 && step == 0) begin
            id_mode = 0;
            return;
        end
        case (step)
            0: step = (m == 16'h5555 && d == 8'hAA) ? 1 : 9;
            1: step = (m == 16'h2AAA && d == 8'h55) ? 2 : 9;
            2: if (m != 16'h5555) step = 9;
               else if (d == 8'hA0) step = 3;
               else if (d == 8'h80) step = 4;
               else if (d == 8'h90) begin id_mode = 1; step = 0; end
               else if (d == 8'hF0) begin id_mode = 0; step = 0; end
               else step = 9;
            3: begin
                mem[a] = rd_val(a) & d;
                d_prog = d;
                start(PROG_CYC, 0);
            end
            4: step = (m == 16'h5555 && d == 8'hAA) ? 5 : 9;
            5: step = (m == 16'h2AAA && d == 8'h55) ? 6 : 9;
            6: if (m == 16'h5555 && d == 8'h10) begin
                mem.delete();
                start(ERASE_CYC, 1);
            end else if (d == 8'h30) begin
                foreach (mem[k]) if (k[16:12] == a[16:12]) mem[k] = 8'hFF;
                start(ERASE_CYC, 1);
            end else step = 9;
            default: ;
        endcase
        if (step == 9) begin
            bad_cnt++;
            step = 0;
        end
    endtask

    // Pins sampled on the clock, so a pulse under one period counts only if it spans a rising edge
    always @(posedge clk) begin
        if (busy > 0) begin
            busy--;
            if (busy == 0 && !erasing) settle = SETTLE_CYC;
        end else if (settle > 0) settle--;
        if (wr_act && !wr_prev) a_lat = addr;
        if (wr_act) begin
            d_lat = dq_out;
            if (dq_oe_n) bad_cnt++;
        end
        if (!wr_act && wr_prev) take(a_lat, d_lat);
        if (rd_act && !rd_prev && busy > 0) tog = ~tog;
        if (rd_act) begin
            if (busy > 0 && erasing) out = {1'b0, tog, 6'($urandom)};
            else if (busy > 0) out = {~d_prog[7], tog, 6'($urandom)};
            else if (settle > 0) out = (rd_val(addr) & 8'h80) | {1'b0, tog, 6'($urandom)};
            else if (id_mode) out = (addr == 17'h00000) ? MAKER_CODE : (addr == 17'h00001) ? PART_CODE : 8'hFF;
            else out = rd_val(addr);
            last = out;
            dq_in <= out;
        end else dq_in <= ~last;
        wr_prev = wr_act;
        rd_prev = rd_act;
    end
endmodule

/* File: testbench/fcs_host_tb_top.sv */
// Self-checking bench for the flash host controller against a device model.
`timescale 1ns/1ps
module fcs_host_tb_top;
    import fcs_pkg::*;
    localparam int SETTLE = 5;
    localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
    localparam logic [7:0] PART = 8'hC3; // Arbitrary value
    logic clk = 0, sys_rst = 1, cmd_valid = 0, cmd_ready, rsp_valid, ce_n, oe_n, we_n, dq_oe_n;
    fcs_op_e cmd_op = FCS_OP_READ;
    logic [16:0] cmd_addr = '0, addr;
    logic [7:0] cmd_data = '0, rsp_data, dq_out, dq_in;
    logic [7:0] shadow [bit [16:0]];
    logic [16:0] corner [4] = '{17'h1FFFF, 17'h00000, 17'h15555, 17'h1FFFF};
    int num_errors = 0, total_checks = 0, cycles = 0;

    fcs_host #(.SETTLE_CYC(SETTLE)) DUT (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .addr(addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
    fcs_flash_model #(.SETTLE_CYC(SETTLE), .MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash (
        .clk(clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .dq_in(dq_in));

    // 100 MHz clock
    initial forever #5 clk = ~clk;

    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            close_out();
        end
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [7:0] exp_at(input logic [16:0] a);
        return shadow.exists(a) ? shadow[a] : 8'hFF;
    endfunction

    // One command, then wait for its response pulse at settled times
    task automatic run(input fcs_op_e op, input logic [16:0] a, input logic [7:0] d, output logic [7:0] r);
        int n;
        @(posedge clk);
        cmd_valid <= 1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        @(posedge clk);
        cmd_valid <= 0;
        n = 0;
        @(negedge clk);
        while (rsp_valid !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        // A response that never comes counts against the run
        if (rsp_valid !== 1'b1) begin
            num_errors++;
            $display("mismatch response expected 1 seen %b", rsp_valid);
        end
        r = rsp_data;
    endtask

    task automatic rd_chk(input logic [16:0] a);
        logic [7:0] r;
        run(FCS_OP_READ, a, 8'h00, r);
        chk("array read", exp_at(a), r);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [16:0] a;
        logic [7:0] d, r;
        logic [16:0] used [$];
        void'($urandom(32'h4a57));
        repeat (10) @(posedge clk);
        sys_rst <= 0;
        @(negedge clk);
        chk("idle pins", 8'h2F, {2'h0, cmd_ready, rsp_valid, ce_n, oe_n, we_n, dq_oe_n});
        // Programs: corners (top address twice, unlock-like address) then random
        for (int i = 0; i < 12; i++) begin
            a = (i < 4) ? corner[i] : 17'($urandom);
            d = 8'($urandom);
            shadow[a] = exp_at(a) & d;
            used.push_back(a);
            run(FCS_OP_PROGRAM, a, d, r);
            chk("program result", shadow[a], r);
            rd_chk(a);
        end
        $display("test program done");
        // Sector erase hits only the addressed 4 KByte sector
        for (int i = 0; i < 3; i++) begin
            a = (i == 0) ? 17'h15FFF : (i == 1) ? 17'h14FFF : 17'h16000;
            shadow[a] = exp_at(a) & 8'h5A;
            run(FCS_OP_PROGRAM, a, 8'h5A, r);
        end
        run(FCS_OP_SECTOR_ERASE, 17'h15ABC, 8'h00, r);
        chk("sector erase result", 8'hFF, r);
        foreach (shadow[k]) if (k[16:12] == 5'h15) shadow[k] = 8'hFF;
        rd_chk(17'h15FFF);
        rd_chk(17'h15555);
        rd_chk(17'h14FFF);
        rd_chk(17'h16000);
        $display("test sector erase done");
        // Identification with both exits
        for (int i = 0; i < 2; i++) begin
            run(FCS_OP_ID_ENTRY, 17'h00000, 8'h00, r);
            run(FCS_OP_READ, 17'h00000, 8'h00, r);
            chk("maker code", MAKER, r);
            run(FCS_OP_READ, 17'h00001, 8'h00, r);
            chk("part code", PART, r);
            run(i ? FCS_OP_ID_EXIT_LONG : FCS_OP_ID_EXIT, 17'h00000, 8'h00, r);
            rd_chk(17'h00000);
            rd_chk(17'h00001);
        end
        $display("test identification done");
        // Second reset at idle: pins and handshake return to rest levels
        @(posedge clk);
        sys_rst <= 1;
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        @(negedge clk);
        chk("idle pins after reset", 8'h2F, {2'h0, cmd_ready, rsp_valid, ce_n, oe_n, we_n, dq_oe_n});
        $display("test second reset done");
        // Chip erase returns every byte to all ones
        run(FCS_OP_CHIP_ERASE, 17'h00000, 8'h00, r);
        chk("chip erase result", 8'hFF, r);
        shadow.delete();
        foreach (used[i]) rd_chk(used[i]);
        for (int i = 0; i < 6; i++) rd_chk(17'($urandom));
        $display("test chip erase done");
        chk("sequence aborts", 8'h00, 8'(u_flash.bad_cnt));
        chk("writes while busy", 8'h00, 8'(u_flash.ignored_cnt));
        close_out();
    end
endmodule
